// ---- bench/flash_model.sv ----
// behavioural model of the parallel nor flash seen from the controller's pins
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter int BUSY_CYC = 40,
    parameter int ERASE_CYC = 200,
    parameter int END_GAP = 4,
    parameter int SLEEP_CYC = 4,
    parameter logic [3:0] PROT = 4'h2
) (
    input wire logic clk,
    input wire logic supply_low,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_host,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic byte_n,
    output logic [15:0] dq_dev,
    output logic [15:0] dq_dev_oe,
    output logic rdy
);
    logic [15:0] mem [16];
    logic [15:0] lat_d, pd, word, held;
    logic [3:0] lat_w, pw;
    logic [19:0] addr_q = 20'h00000;
    logic [1:0] esec = 2'h0;
    logic we_q = 1'b1;
    logic bypass = 1'b0, esusp = 1'b0;
    int cnt = 0, gap = 0, busy = 0, ebusy = 0, still = 0;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    end
    // small boot sectors at the bottom, then larger ones
    function automatic logic [1:0] sec(input logic [3:0] w);
        return (w < 4'h2) ? 2'h0 : (w < 4'h4) ? 2'h1 : (w < 4'h8) ? 2'h2 : 2'h3;
    endfunction
    // ===========================================
    // command sequencing
    always @(posedge clk) begin
        we_q <= we_n;
        addr_q <= addr;
        // sleep once the address stands still; output data stays latched
        if (addr != addr_q) still <= 0;
        else if (still < SLEEP_CYC) still <= still + 1;
        if (still < SLEEP_CYC) held <= word;
        if (!rst_n) begin
            cnt <= 0;
            busy <= 0;
            ebusy <= 0;
            esusp <= 1'b0;
            bypass <= 1'b0;
        end else begin
            if (!we_n && !ce_n && !supply_low) begin
                lat_w <= addr[3:0];
                lat_d <= dq_host;
            end
            if (!we_n) gap <= 0;
            else if (!we_q && !supply_low) cnt <= cnt + 1;
            else if (cnt != 0 && gap < END_GAP) gap <= gap + 1;
            else if (cnt != 0) begin
                cnt <= 0;
                if (cnt == 1 && ebusy != 0) esusp <= !esusp;
                else if (cnt == 3) bypass <= 1'b1;
                else if (!PROT[sec(lat_w)] && busy == 0) begin
                    if (cnt == 6 && ebusy == 0) begin
                        esec <= sec(lat_w);
                        ebusy <= ERASE_CYC;
                    end else if ((cnt == 4 || (cnt == 2 && bypass))
                            && (ebusy == 0 || (esusp && sec(lat_w) != esec))) begin
                        pw <= lat_w;
                        pd <= lat_d;
                        busy <= BUSY_CYC;
                    end
                end
                // any other length is dropped without touching the array
            end
            if (busy > 1) busy <= busy - 1;
            else if (busy == 1) begin
                mem[pw] <= pd;
                busy <= 0;
                still <= 0;
            end
            if (ebusy > 1 && !esusp) ebusy <= ebusy - 1;
            else if (ebusy == 1 && !esusp) begin
                for (int i = 0; i < 16; i++) begin
                    if (sec(4'(i)) == esec) mem[i] <= 16'hffff;
                end
                ebusy <= 0;
                still <= 0;
            end
        end
    end
    // pin is open drain with a pull-up: high when no program runs and no erase runs unless it is suspended
    assign rdy = (busy == 0) && (ebusy == 0 || esusp);
    // ===========================================
    // read drive
    always @* begin
        dq_dev = 16'h0000;
        dq_dev_oe = 16'h0000;
        word = mem[addr[3:0]];
        if (still >= SLEEP_CYC) word = held;
        if (rst_n && !ce_n && !oe_n) begin
            if (byte_n) begin
                dq_dev = word;
                dq_dev_oe = 16'hffff;
            end else begin
                dq_dev = {8'h00, dq_host[15] ? word[15:8] : word[7:0]};
                dq_dev_oe = 16'h00ff;
            end
        end
    end
endmodule // flash_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking testbench of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ready_busy_out, chip_sel_n, out_drive_n;
    logic write_strobe_n, flash_reset_n, byte_mode_n, saw_busy = 1'b0, saw_rst = 1'b0;
    logic supply_low = 1'b0;
    logic [19:0] flash_addr;
    logic [15:0] dq_out, dq_oe, dq_in, dq_dev, dq_dev_oe, float_pat = 16'h5a5a;
    int num_errors = 0, total_checks = 0;
    always #5 pclk = ~pclk;
    // released lines show a pattern that changes every cycle
    always @(posedge pclk) float_pat <= ~float_pat;
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & dq_dev_oe & dq_dev) | (~dq_oe & ~dq_dev_oe & float_pat);
    flash_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
        .write_strobe_n(write_strobe_n), .flash_reset_n(flash_reset_n),
        .byte_mode_n(byte_mode_n), .ready_busy_out(ready_busy_out));
    flash_model model (.clk(pclk), .supply_low(supply_low), .addr(flash_addr),
        .dq_host(dq_in), .ce_n(chip_sel_n),
        .oe_n(out_drive_n), .we_n(write_strobe_n), .rst_n(flash_reset_n),
        .byte_n(byte_mode_n), .dq_dev(dq_dev), .dq_dev_oe(dq_dev_oe), .rdy(ready_busy_out));
    // ===========================================
    // helpers
    function automatic void chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endfunction
    task automatic conclude;
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input int i, input logic [20:0] a, input logic [15:0] d);
        apb(1'b1, 8'h40 + 8'(8 * i), {11'h0, a});
        apb(1'b1, 8'h44 + 8'(8 * i), {16'h0, d});
    endtask
    task automatic run(input logic [7:0] c);
        int n;
        n = 0;
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h00, {24'h0, c});
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 3000);
        chk({31'h0, rd[1]}, 32'h1, "operation done");
    endtask
    // program sequence of n writes, waiting on the ready pin
    function automatic logic [7:0] prog(input logic [2:0] n);
        return {4'b0010, n, 1'b1};
    endfunction
    task automatic rdchk(input logic [20:0] a, input logic bm, input logic [31:0] exp);
        apb(1'b1, 8'h0c, {11'h0, a});
        run({1'b0, bm, 2'b01, 3'd0, 1'b1});
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, exp, "array data");
    endtask
    // ===========================================
    // pin monitors
    always @(posedge pclk) begin
        if (presetn) begin
            if (!ready_busy_out) saw_busy <= 1'b1;
            if (!flash_reset_n) saw_rst <= 1'b1;
            chk({16'h0, dq_oe & dq_dev_oe}, 32'h0, "bus contention");
            if (!out_drive_n) chk({16'h0, dq_oe}, byte_mode_n ? 32'h0 : 32'h8000, "read drive");
            if (!write_strobe_n) chk({31'h0, out_drive_n}, 32'h1, "write drive");
        end
    end
    // ===========================================
    // tests
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0, "control after reset");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h4, "status after reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped access");
        for (int i = 0; i < 3; i++) load(i, 21'(i + 1), 16'(8'ha0 + i));
        load(3, 21'h5, 16'h1234);
        run(prog(3'd4));
        chk({31'h0, saw_busy}, 32'h1, "busy seen on ready pin");
        rdchk(21'h5, 1'b0, 32'h1234);
        load(3, 21'h6, 16'h0000);
        load(4, 21'h6, 16'hbeef);
        run(prog(3'd5));
        rdchk(21'h6, 1'b0, 32'hffff);
        load(1, 21'h8, 16'h0077);
        run(prog(3'd2));
        rdchk(21'h8, 1'b0, 32'hffff);
        run(prog(3'd3));
        load(1, 21'h7, 16'h00a5);
        run(prog(3'd2));
        rdchk(21'h7, 1'b0, 32'h00a5);
        rdchk(21'hb, 1'b1, 32'h12);
        rdchk(21'ha, 1'b1, 32'h34);
        load(1, 21'h9, 16'h4321);
        run(8'h05);
        run(8'h80);
        chk({30'h0, saw_rst, ready_busy_out}, 32'h3, "reset pulse aborts");
        rdchk(21'h9, 1'b0, 32'hffff);
        run(prog(3'd2));
        rdchk(21'h9, 1'b0, 32'hffff);
        load(3, 21'h3, 16'h3333);
        run(prog(3'd4));
        rdchk(21'h3, 1'b0, 32'hffff);
        supply_low <= 1'b1;
        load(3, 21'h4, 16'h4444);
        run(prog(3'd4));
        supply_low <= 1'b0;
        rdchk(21'h4, 1'b0, 32'hffff);
        load(5, 21'h5, 16'h0030);
        run(8'h0d);
        load(0, 21'h5, 16'h00b0);
        run(8'h03);
        load(3, 21'hc, 16'h0c0c);
        run(prog(3'd4));
        run(prog(3'd1));
        rdchk(21'h5, 1'b0, 32'hffff);
        rdchk(21'h7, 1'b0, 32'hffff);
        rdchk(21'hc, 1'b0, 32'h0c0c);
        conclude();
    end
    initial begin
        #400000;
        num_errors++;
        conclude();
    end
endmodule // tb
`default_nettype wire

// ---- rtl/flash_host.sv ----
// apb-programmed host controller that drives a parallel nor flash through its pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host #(
    parameter int T_WP_NS = `T_WP_NS,
    parameter int T_RP_NS = `T_RP_NS,
    parameter int T_RH_NS = `T_RH_NS,
    parameter int T_BUSY_NS = `T_BUSY_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] flash_addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [15:0] dq_oe,
    output logic chip_sel_n,
    output logic out_drive_n,
    output logic write_strobe_n,
    output logic flash_reset_n,
    output logic byte_mode_n,
    input wire logic ready_busy_out
);
    import flash_host_pkg::*;

    localparam logic [7:0] CYC_ACC = 8'(`CYC_UP(`T_ACC_NS) + 2);
    localparam logic [7:0] CYC_WP = 8'(`CYC_UP(T_WP_NS));
    localparam logic [7:0] CYC_RP = 8'(`CYC_UP(T_RP_NS));
    localparam logic [7:0] CYC_RH = 8'(`CYC_UP(T_RH_NS));
    localparam logic [7:0] CYC_BUSY = 8'(`CYC_UP(T_BUSY_NS) + 2);

    // =====================================================
    // pin helpers
    function automatic logic [19:0] pin_addr(input flash_addr_t a, input logic bm);
        pin_addr = bm ? a[20:1] : a[19:0];
    endfunction

    function automatic logic [15:0] pin_dq(input flash_addr_t a, input logic [15:0] d,
                                           input logic bm);
        pin_dq = bm ? {a[0], 7'h00, d[7:0]} : d;
    endfunction

    // =====================================================
    // input synchronisers
    logic [15:0] dq_s1_q, dq_s2_q;
    logic rb_s1_q, rb_s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            rb_s1_q <= ready_busy_out;
            rb_s2_q <= rb_s1_q;
        end
    end

    // =====================================================
    // registers and sequencer
    host_state_e st_q, st_d;
    logic [7:0] tmr_q, tmr_d;
    logic [2:0] idx_q, idx_d, cnt_q, cnt_d;
    logic rd_q, rd_d, wait_q, wait_d, byte_q, byte_d, done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    flash_addr_t raddr_q, raddr_d;
    flash_addr_t seq_a_q [`SEQ_DEPTH];
    flash_addr_t seq_a_d [`SEQ_DEPTH];
    logic [15:0] seq_d_q [`SEQ_DEPTH];
    logic [15:0] seq_d_d [`SEQ_DEPTH];
    logic [19:0] addr_q, addr_d;
    logic [15:0] dqo_q, dqo_d, dqe_q, dqe_d;
    logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rst_n_q, rst_n_d;
    logic wr_acc, rd_acc, busy, seq_hit;
    logic [2:0] seq_idx;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign busy = (st_q != ST_IDLE);
    assign seq_idx = 3'(paddr[5:3]);
    assign seq_hit = (paddr[7:6] == 2'(`OFS_SEQ >> 6)) && (seq_idx < 3'(`SEQ_DEPTH))
                     && (paddr[1:0] == 2'b00);

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd_acc || wr_acc) begin
            case (paddr)
                `OFS_CTRL: prdata = {24'h0, 1'b0, byte_q, wait_q, rd_q, cnt_q, 1'b0};
                `OFS_STATUS: prdata = {29'h0, rb_s2_q, done_q, busy};
                `OFS_RDATA: prdata = {16'h0, rdata_q};
                `OFS_RADDR: prdata = {11'h0, raddr_q};
                default: begin
                    if (seq_hit) begin
                        prdata = paddr[2] ? {16'h0, seq_d_q[seq_idx]}
                                          : {11'h0, seq_a_q[seq_idx]};
                    end else begin
                        pslverr = 1'b1;
                    end
                end
            endcase
        end
    end
    assign pready = 1'b1;

    always_comb begin
        st_d = st_q;
        tmr_d = (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
        idx_d = idx_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        wait_d = wait_q;
        byte_d = byte_q;
        done_d = done_q;
        rdata_d = rdata_q;
        raddr_d = raddr_q;
        seq_a_d = seq_a_q;
        seq_d_d = seq_d_q;
        addr_d = addr_q;
        dqo_d = dqo_q;
        dqe_d = dqe_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        rst_n_d = rst_n_q;
        // software clear of done; a completion in the same cycle still sets it
        if (wr_acc && paddr == `OFS_STATUS && pwdata[`ST_DONE]) begin
            done_d = 1'b0;
        end
        if (wr_acc && !busy) begin
            if (paddr == `OFS_RADDR) begin
                raddr_d = pwdata[20:0];
            end
            if (seq_hit && paddr[2]) begin
                seq_d_d[seq_idx] = pwdata[15:0];
            end else if (seq_hit) begin
                seq_a_d[seq_idx] = pwdata[20:0];
            end
            if (paddr == `OFS_CTRL) begin
                cnt_d = pwdata[`CTRL_CNT_LO +: 3];
                rd_d = pwdata[`CTRL_RD];
                wait_d = pwdata[`CTRL_WAIT];
                byte_d = pwdata[`CTRL_BYTE];
            end
        end
        case (st_q)
            ST_IDLE: begin
                ce_n_d = 1'b1;
                oe_n_d = 1'b1;
                we_n_d = 1'b1;
                dqe_d = 16'h0000;
                idx_d = 3'h0;
                if (wr_acc && paddr == `OFS_CTRL && pwdata[`CTRL_HWRST]) begin
                    rst_n_d = 1'b0;
                    tmr_d = CYC_RP;
                    st_d = ST_RSTLOW;
                end else if (wr_acc && paddr == `OFS_CTRL && pwdata[`CTRL_GO]) begin
                    // any sequence may be issued, suspend and resume included
                    if (pwdata[`CTRL_CNT_LO +: 3] != 3'h0) begin
                        st_d = ST_WSETUP;
                    end else if (pwdata[`CTRL_RD]) begin
                        st_d = ST_RACC;
                        tmr_d = CYC_ACC;
                    end else begin
                        done_d = 1'b1;
                    end
                end
            end
            ST_WSETUP: begin
                // select low, output drive high, data on the pins before the strobe
                ce_n_d = 1'b0;
                oe_n_d = 1'b1;
                addr_d = pin_addr(seq_a_q[idx_q], byte_q);
                dqo_d = pin_dq(seq_a_q[idx_q], seq_d_q[idx_q], byte_q);
                dqe_d = byte_q ? 16'h80ff : 16'hffff;
                tmr_d = CYC_WP;
                st_d = ST_WPULSE;
            end
            ST_WPULSE: begin
                we_n_d = 1'b0;
                if (tmr_q == 8'h00 && !we_n_q) begin
                    we_n_d = 1'b1;
                    st_d = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                ce_n_d = 1'b1;
                dqe_d = 16'h0000;
                idx_d = idx_q + 3'h1;
                // two writes in bypass, four standard: the count decides
                if (idx_q + 3'h1 < cnt_q) begin
                    st_d = ST_WSETUP;
                end else if (wait_q) begin
                    tmr_d = CYC_BUSY;
                    st_d = ST_BUSYGAP;
                end else if (rd_q) begin
                    tmr_d = CYC_ACC;
                    st_d = ST_RACC;
                end else begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_BUSYGAP: begin
                if (tmr_q == 8'h00) begin
                    st_d = ST_WAITRB;
                end
            end
            ST_WAITRB: begin
                if (rb_s2_q) begin
                    if (rd_q) begin
                        tmr_d = CYC_ACC;
                        st_d = ST_RACC;
                    end else begin
                        done_d = 1'b1;
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_RACC: begin
                // select and output drive low, write strobe high
                ce_n_d = 1'b0;
                oe_n_d = 1'b0;
                we_n_d = 1'b1;
                addr_d = pin_addr(raddr_q, byte_q);
                dqo_d = pin_dq(raddr_q, 16'h0000, byte_q);
                dqe_d = byte_q ? 16'h8000 : 16'h0000;
                if (tmr_q == 8'h00) begin
                    rdata_d = byte_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
                    st_d = ST_RDONE;
                end
            end
            ST_RDONE: begin
                ce_n_d = 1'b1;
                oe_n_d = 1'b1;
                dqe_d = 16'h0000;
                done_d = 1'b1;
                st_d = ST_IDLE;
            end
            ST_RSTLOW: begin
                if (tmr_q == 8'h00) begin
                    rst_n_d = 1'b1;
                    tmr_d = CYC_RH;
                    st_d = ST_RSTHIGH;
                end
            end
            ST_RSTHIGH: begin
                if (tmr_q == 8'h00) begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            tmr_q <= 8'h00;
            idx_q <= 3'h0;
            cnt_q <= 3'h0;
            rd_q <= 1'b0;
            wait_q <= 1'b0;
            byte_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            raddr_q <= 21'h000000;
            for (int i = 0; i < `SEQ_DEPTH; i++) begin
                seq_a_q[i] <= 21'h000000;
                seq_d_q[i] <= 16'h0000;
            end
            addr_q <= 20'h00000;
            dqo_q <= 16'h0000;
            dqe_q <= 16'h0000;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rst_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wait_q <= wait_d;
            byte_q <= byte_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            raddr_q <= raddr_d;
            seq_a_q <= seq_a_d;
            seq_d_q <= seq_d_d;
            addr_q <= addr_d;
            dqo_q <= dqo_d;
            dqe_q <= dqe_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            rst_n_q <= rst_n_d;
        end
    end

    assign flash_addr = addr_q;
    assign dq_out = dqo_q;
    assign dq_oe = dqe_q;
    assign chip_sel_n = ce_n_q;
    assign out_drive_n = oe_n_q;
    assign write_strobe_n = we_n_q;
    assign flash_reset_n = rst_n_q;
    assign byte_mode_n = !byte_q;

    // =====================================================
    // assertions
    AST_READ_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
        !oe_n_q |-> !ce_n_q && we_n_q && dqe_q[14:0] == 15'h0000)
        else $error("read cycle with wrong control levels");

    AST_WRITE_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(we_n_q) |-> !ce_n_q && oe_n_q && $past(!ce_n_q) && dqe_q[7:0] == 8'hff)
        else $error("write strobe without select or with output drive");

    AST_STROBE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(we_n_q) |-> !we_n_q [*2] ##0 ce_n_q == 1'b0)
        else $error("write strobe too short");

    AST_BYTE_LOWADDR: assert property (@(posedge pclk) disable iff (!presetn)
        (byte_q && dqe_q != 16'h0000) |-> dqe_q[15] && dqe_q[14:8] == 7'h00)
        else $error("byte mode pin drive wrong");

    AST_WRITE_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_WHOLD && idx_q + 3'h1 >= cnt_q) |=> st_q != ST_WSETUP && idx_q == cnt_q)
        else $error("write cycle count differs from programmed count");

    AST_WAIT_READY: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_WAITRB && !rb_s2_q) |=> busy && !$rose(done_q))
        else $error("completion reported while device busy");

    AST_IDLE_RELEASED: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> ce_n_q && we_n_q && dqe_q == 16'h0000)
        else $error("bus not released between sequences");

    COV_WRITE_SEQ: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_WHOLD ##1 st_q == ST_WSETUP);
    COV_WAIT_READY: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_WAITRB ##1 st_q == ST_IDLE);
    COV_BYTE_READ: cover property (@(posedge pclk) disable iff (!presetn)
        byte_q && st_q == ST_RDONE);
    COV_HW_RESET: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(rst_n_q));
endmodule // flash_host
`default_nettype wire

// ---- rtl/flash_host_cfg.svh ----
// offsets, field positions and timing counts of the parallel flash host controller
// Function
// - bypass program takes two writes, standard four
// - completion seen on ready pin or status
// - erase may be suspended, then resumed
// - eight-bit mode: top data pin is address
// - read: select and output low, write high
// - write: write and select low, output high
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RDATA 8'h08
`define OFS_RADDR 8'h0c
`define OFS_SEQ 8'h40
`define SEQ_DEPTH 6
`define CTRL_GO 0
`define CTRL_CNT_LO 1
`define CTRL_RD 4
`define CTRL_WAIT 5
`define CTRL_BYTE 6
`define CTRL_HWRST 7
`define ST_BUSY 0
`define ST_DONE 1
`define ST_READY 2
`define CLK_NS 10
`define T_ACC_NS 70
`define T_WP_NS 50
`define T_RP_NS 500
`define T_RH_NS 50
`define T_BUSY_NS 100
`define CYC_UP(t) (((t) + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- rtl/flash_host_pkg.sv ----
// types of the parallel flash host controller
package flash_host_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_BUSYGAP, ST_WAITRB,
        ST_RACC, ST_RDONE, ST_RSTLOW, ST_RSTHIGH
    } host_state_e;
    typedef logic [20:0] flash_addr_t;
endpackage
